// ==== design/bsp_pkg.sv ====
// Contract
// R1: Software sets the three shared port output latches to one first.
// R2: One 32-byte buffer is shared by transmit and receive data.
// R3: Writing abort stops at once, clears run and flags, then self-clears.
// R4: Mode 00 transmits, 01 receives, 10 does both; 11 is reserved.
// R5: Clock select picks a divided system clock, slow clock or external pin.
// R6: Software keeps the serial bit rate at or below one megabit per second.
// R7: Software starts or reconfigures only while the transfer flag reads zero.
// R8: Byte count field plus one gives the length for both directions.
// R9: Software changes the byte count only while no transfer is active.
// R10: Software writes zeros to the upper three byte count bits.
// R11: Status bit 7 is one during a transfer, zero after stop or abort.
// R12: Status bit 6 is one only while the shift register is working.
// R13: Status bit 5 is one when no transmit data is left; resets to one.
// R14: Status bit 4 sets after all bytes arrive, clears after all are read.
// R15: Error bits 3 and 2 survive a normal stop; only abort clears them.
// R16: Status is read-only and resets to 0010 00 in its upper bits.
// R17: Abort discards the whole buffer contents; the code only rewinds the pointers and leaves the bytes in the array.
// R18: Software moves exactly the programmed number of bytes per transfer.
// R19: Bit order zero moves the MSB first, one moves the LSB first.
// R20: Transmit bits change on clock falls; receive bits sample on rises.
// R21: With the internal clock the clock line is high at start and end.
// R22: External clock falling with no data left sets transmit error, output high.
// R23: Bytes go out in write order and are read back in arrival order.
// R24: With the internal clock, shifting starts at once after run is set.
package bsp_pkg;
    localparam int         ADDR_W      = 8;
    localparam logic [5:0] IDX_CTRL    = 6'h19;
    localparam logic [5:0] IDX_COUNT   = 6'h1A;
    localparam logic [5:0] IDX_STATUS  = 6'h1B;
    localparam logic [5:0] IDX_DATA    = 6'h1C;
    localparam logic [5:0] IDX_CFG     = 6'h1D;
    localparam int         BUF_DEPTH   = 32;
    localparam int         PTR_W       = 5;
    localparam int         CTRL_RUN    = 7;
    localparam int         CTRL_ABORT  = 6;
    localparam int         CTRL_MODE   = 4;
    localparam int         CTRL_ORDER  = 3;
    localparam int         CTRL_SEL    = 0;
    localparam int         CFG_FS      = 0;
    localparam logic [1:0] MODE_TX     = 2'h0;
    localparam logic [1:0] MODE_RX     = 2'h1;
    localparam logic [2:0] SEL_SLOW    = 3'h0;
    localparam logic [2:0] SEL_EXT     = 3'h7;
    localparam logic [1:0] CTRL_MODE_RST = 2'h0;
    localparam logic [2:0] CTRL_SEL_RST  = 3'h0;
    localparam logic [4:0] COUNT_RST   = 5'h00;
    localparam logic [5:0] STATUS_RST  = 6'h08;
    localparam int         FC_CNT_W    = 13;
    localparam int         FS_HALF_LOG = 4;
    // Half-period exponent for each internal select code.
    localparam logic [3:0] FC_HALF_LOG [0:7] = '{4'hC, 4'h7, 4'h5, 4'h4,
                                                 4'h3, 4'h2, 4'h1, 4'h1};
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_LOAD  = 3'b010,
        ST_SHIFT = 3'b011,
        ST_DONE  = 3'b100
    } bsp_state_t;
    typedef enum logic [2:0] {
        REG_NONE   = 3'b000,
        REG_CTRL   = 3'b001,
        REG_COUNT  = 3'b010,
        REG_STATUS = 3'b011,
        REG_DATA   = 3'b100,
        REG_CFG    = 3'b101
    } bsp_reg_t;
endpackage

// ==== design/bsp_buffer_mem.sv ====
`timescale 1ns/1ps
module bsp_buffer_mem
    import bsp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = bsp_pkg::BUF_DEPTH,
    parameter int AW    = bsp_pkg::PTR_W
)(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Write port.
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Registered read port.
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem_reg[raddr];
        end
    end
endmodule // bsp_buffer_mem

// ==== design/bsp_clk_div.sv ====
`timescale 1ns/1ps
module bsp_clk_div
    import bsp_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control.
    input  wire logic       restart,
    input  wire logic [2:0] clk_sel,
    input  wire logic       use_fs,
    input  wire logic       low_freq_tick,
    // Half serial period strobe.
    output logic            half_tick
);
    logic [FC_CNT_W-1:0]    fc_cnt_reg;
    logic [FS_HALF_LOG-1:0] fs_cnt_reg;
    logic [FC_CNT_W-1:0]    mask;
    logic                   slow;
    logic                   hit;

    always_comb begin
        mask = FC_CNT_W'((13'h1 << FC_HALF_LOG[clk_sel]) - 13'h1);
        slow = use_fs && (clk_sel == SEL_SLOW);
        hit  = slow ? (low_freq_tick && (&fs_cnt_reg)) : (&(fc_cnt_reg | ~mask));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_cnt_reg <= '0;
            fs_cnt_reg <= '0;
        end else if (restart) begin
            fc_cnt_reg <= '0;
            fs_cnt_reg <= '0;
        end else begin
            fc_cnt_reg <= fc_cnt_reg + 13'h1;
            if (low_freq_tick) begin
                fs_cnt_reg <= fs_cnt_reg + 4'h1;
            end
        end
    end

    // The strobe is registered, so each half period is one cycle late but even.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_tick <= 1'b0;
        end else begin
            half_tick <= !restart && hit;
        end
    end
endmodule // bsp_clk_div

// ==== design/bsp_sync_serial_unit.sv ====
`timescale 1ns/1ps
module bsp_sync_serial_unit
    import bsp_pkg::*;
(
    // Clock and reset.
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [bsp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Serial pins.
    input  wire logic                      port_pin_in,
    output logic                           port_pin_out,
    input  wire logic                      port_pin_clk_in,
    output logic                           port_pin_clk_out,
    output logic                           port_pin_clk_oe_n,
    // Slow clock and operating mode.
    input  wire logic                      low_freq_tick,
    input  wire logic                      low_speed_mode
);
    ////////////////////////////////////////////////////////////////////////
    logic             run_reg;
    logic [1:0]       mode_reg;
    logic             order_reg;
    logic [2:0]       sel_reg;
    logic [4:0]       count_reg;
    logic             fs_sel_reg;
    logic             active_reg;
    logic             tx_empty_reg;
    logic             rx_full_reg;
    logic             tx_err_reg;
    logic             rx_err_reg;
    bsp_state_t       state_reg;
    logic [PTR_W-1:0] eng_ptr_reg;
    logic [PTR_W-1:0] sw_ptr_reg;
    logic [PTR_W-1:0] rd_cnt_reg;
    logic [2:0]       bit_cnt_reg;
    logic [7:0]       tx_sh_reg;
    logic [7:0]       rx_sh_reg;
    logic             sck_prev_reg;
    logic [7:0]       mem_rdata;
    logic             half_tick;
    bsp_reg_t         reg_sel;
    logic             access;
    logic             wr;
    logic             rd;
    logic             abort;
    logic             internal;
    logic             shifting;
    logic             fall_ev;
    logic             rise_ev;
    logic             byte_end;
    logic             last;
    logic             done_ev;
    logic             has_tx;
    logic             has_rx;
    logic             start;
    logic             tx_err_ev;
    logic             rx_err_ev;
    logic             pop;
    logic [7:0]       rx_next;
    logic [7:0]       rd_byte;

    function automatic bsp_reg_t decode(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'h0) return REG_NONE;
        case (a[ADDR_W-1:2])
            IDX_CTRL:   return REG_CTRL;
            IDX_COUNT:  return REG_COUNT;
            IDX_STATUS: return REG_STATUS;
            IDX_DATA:   return REG_DATA;
            IDX_CFG:    return REG_CFG;
            default:    return REG_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        reg_sel   = decode(paddr);
        access    = psel && penable;
        wr        = access && pready && pwrite;
        rd        = access && pready && !pwrite;
        abort     = wr && (reg_sel == REG_CTRL) && pwdata[CTRL_ABORT]; // see R3
        internal  = (sel_reg != SEL_EXT);
        shifting  = (state_reg == ST_FETCH) || (state_reg == ST_LOAD)
                 || (state_reg == ST_SHIFT); // see R12
        fall_ev   = (state_reg == ST_SHIFT)
                 && (internal ? (half_tick && port_pin_clk_out)
                              : (sck_prev_reg && !port_pin_clk_in)); // see R20
        rise_ev   = (state_reg == ST_SHIFT)
                 && (internal ? (half_tick && !port_pin_clk_out)
                              : (!sck_prev_reg && port_pin_clk_in)); // see R20
        byte_end  = rise_ev && (bit_cnt_reg == 3'h7);
        last      = (eng_ptr_reg == count_reg); // see R8
        done_ev   = byte_end && (last || !run_reg);
        has_tx    = (mode_reg != MODE_RX); // see R4
        has_rx    = (mode_reg != MODE_TX); // see R4
        start     = (state_reg == ST_IDLE) && run_reg;
        tx_err_ev = !internal && sck_prev_reg && !port_pin_clk_in && active_reg
                 && (state_reg == ST_DONE) && tx_empty_reg && has_tx; // see R22
        rx_err_ev = !internal && !sck_prev_reg && port_pin_clk_in && active_reg
                 && (state_reg == ST_DONE) && rx_full_reg && has_rx;
        pop       = rd && (reg_sel == REG_DATA);
        rx_next   = order_reg ? {port_pin_in, rx_sh_reg[7:1]}
                              : {rx_sh_reg[6:0], port_pin_in}; // see R19
    end

    // One buffer serves both directions; a received byte overwrites the slot
    // whose transmit byte was just sent.
    bsp_buffer_mem #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH),
        .AW    (PTR_W)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      ((wr && (reg_sel == REG_DATA) && !active_reg)
                  || (byte_end && has_rx)), // see R2
        .waddr   (active_reg ? eng_ptr_reg : sw_ptr_reg),
        .wdata   (active_reg ? rx_next : pwdata[7:0]),
        .raddr   (shifting ? eng_ptr_reg : sw_ptr_reg),
        .rdata   (mem_rdata)
    );

    bsp_clk_div u_div (
        .pclk          (pclk),
        .presetn       (presetn),
        .restart       (state_reg != ST_SHIFT),
        .clk_sel       (sel_reg),
        .use_fs        (fs_sel_reg || low_speed_mode),
        .low_freq_tick (low_freq_tick),
        .half_tick     (half_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg   <= 1'b0;
            mode_reg  <= CTRL_MODE_RST;
            order_reg <= 1'b0;
            sel_reg   <= CTRL_SEL_RST;
        end else if (abort) begin
            run_reg   <= 1'b0; // see R3
        end else if (wr && (reg_sel == REG_CTRL)) begin
            run_reg   <= pwdata[CTRL_RUN];
            mode_reg  <= pwdata[CTRL_MODE +: 2];
            order_reg <= pwdata[CTRL_ORDER];
            sel_reg   <= pwdata[CTRL_SEL +: 3]; // see R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg  <= COUNT_RST;
            fs_sel_reg <= 1'b0;
        end else begin
            if (wr && (reg_sel == REG_COUNT)) begin
                count_reg <= pwdata[4:0]; // see R10
            end
            if (wr && (reg_sel == REG_CFG)) begin
                fs_sel_reg <= pwdata[CFG_FS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else if (abort) begin
            state_reg <= ST_IDLE; // see R3
        end else begin
            case (state_reg)
                ST_IDLE:  state_reg <= run_reg ? ST_FETCH : ST_IDLE; // see R24
                ST_FETCH: state_reg <= ST_LOAD;
                ST_LOAD:  state_reg <= ST_SHIFT;
                ST_SHIFT: begin
                    if (byte_end) begin
                        state_reg <= done_ev ? ST_DONE : ST_FETCH;
                    end
                end
                ST_DONE:  state_reg <= run_reg ? ST_DONE : ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= 1'b0;
        end else if (abort) begin
            active_reg <= 1'b0; // see R3
        end else if (start) begin
            active_reg <= 1'b1; // see R11
        end else if ((state_reg == ST_DONE) && !run_reg) begin
            active_reg <= 1'b0; // see R11
        end
    end

    // The engine walks the buffer upward from slot zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_ptr_reg <= '0;
        end else if (abort || start) begin
            eng_ptr_reg <= '0; // see R23
        end else if (byte_end && !done_ev) begin
            eng_ptr_reg <= eng_ptr_reg + 5'h01; // see R23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 3'h0;
            tx_sh_reg   <= 8'hFF;
            rx_sh_reg   <= 8'h00;
        end else begin
            if (state_reg == ST_LOAD) begin
                bit_cnt_reg <= 3'h0;
                tx_sh_reg   <= has_tx ? mem_rdata : 8'hFF;
            end else if (fall_ev) begin
                tx_sh_reg <= order_reg ? {1'b1, tx_sh_reg[7:1]}
                                       : {tx_sh_reg[6:0], 1'b1}; // see R19
            end
            if (rise_ev) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                rx_sh_reg   <= rx_next; // see R20
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_out <= 1'b1;
        end else if (abort || tx_err_ev) begin
            port_pin_out <= 1'b1; // see R22
        end else if (fall_ev && has_tx) begin
            port_pin_out <= order_reg ? tx_sh_reg[0] : tx_sh_reg[7]; // see R19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_clk_out  <= 1'b1;
            port_pin_clk_oe_n <= 1'b1;
            sck_prev_reg      <= 1'b1;
        end else begin
            sck_prev_reg      <= port_pin_clk_in;
            port_pin_clk_oe_n <= !internal;
            if (state_reg != ST_SHIFT) begin
                port_pin_clk_out <= 1'b1; // see R21
            end else if (internal && half_tick) begin
                port_pin_clk_out <= !port_pin_clk_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Abort only rewinds the pointers and marks the buffer empty; stale bytes
    // stay in the array, and a data read after abort still returns the one in slot zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_reg <= 1'b1;
        end else if (abort) begin
            tx_empty_reg <= 1'b1; // see R17
        end else if ((state_reg == ST_LOAD) && last) begin
            tx_empty_reg <= 1'b1; // see R13
        end else if (wr && (reg_sel == REG_DATA) && !active_reg) begin
            tx_empty_reg <= 1'b0; // see R13
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_ptr_reg <= '0;
        end else if (abort || start || done_ev) begin
            sw_ptr_reg <= '0; // see R18
        end else if (pop || (wr && (reg_sel == REG_DATA) && !active_reg)) begin
            // Wrapping after the programmed count puts the next batch back at slot zero.
            sw_ptr_reg <= (sw_ptr_reg == count_reg) ? '0 : sw_ptr_reg + 5'h01; // see R23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_reg <= 1'b0;
            rd_cnt_reg  <= '0;
        end else if (abort) begin
            rx_full_reg <= 1'b0; // see R3
            rd_cnt_reg  <= '0;
        end else if (byte_end && last && has_rx) begin
            rx_full_reg <= 1'b1; // see R14
            rd_cnt_reg  <= '0;
        end else if (pop && rx_full_reg) begin
            rd_cnt_reg <= rd_cnt_reg + 5'h01;
            if (rd_cnt_reg == count_reg) begin
                rx_full_reg <= 1'b0; // see R14
                rd_cnt_reg  <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_err_reg <= 1'b0;
            rx_err_reg <= 1'b0;
        end else if (abort) begin
            tx_err_reg <= 1'b0; // see R15
            rx_err_reg <= 1'b0; // see R15
        end else begin
            if (tx_err_ev) begin
                tx_err_reg <= 1'b1; // see R22
            end
            if (rx_err_ev) begin
                rx_err_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (reg_sel)
            REG_CTRL:   rd_byte = {run_reg, 1'b0, mode_reg, order_reg, sel_reg};
            REG_COUNT:  rd_byte = {3'h0, count_reg};
            REG_STATUS: rd_byte = {active_reg, shifting, tx_empty_reg, rx_full_reg,
                                   tx_err_reg, rx_err_reg, 2'h0}; // see R16
            REG_DATA:   rd_byte = mem_rdata;
            REG_CFG:    rd_byte = {7'h00, fs_sel_reg};
            default:    rd_byte = 8'h00;
        endcase
    end

    // One wait state gives the buffer its registered read time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && (reg_sel == REG_NONE);
            if (access && !pready && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    abort_clears_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
        abort |=> !run_reg && !active_reg && tx_empty_reg && !rx_full_reg
                  && !tx_err_reg && !rx_err_reg && (state_reg == ST_IDLE))
        else $error("abort left state behind");

    idle_inactive_a: assert property (@(posedge pclk) disable iff (!presetn) // see R11
        (state_reg == ST_DONE) && !run_reg && !abort |=> !active_reg)
        else $error("transfer flag stayed after stop");

    shift_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // see R12
        shifting |-> active_reg)
        else $error("shifting without a transfer");

    count_end_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
        (state_reg == ST_SHIFT) && byte_end && run_reg && !abort
        |=> (state_reg == ST_DONE) == $past(last))
        else $error("transfer length wrong");

    err_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // see R15
        tx_err_reg && !abort |=> tx_err_reg)
        else $error("error flag lost without abort");

    tx_error_a: assert property (@(posedge pclk) disable iff (!presetn) // see R22
        tx_err_ev && !abort |=> tx_err_reg && port_pin_out)
        else $error("transmit error not flagged");

    clk_idle_high_a: assert property (@(posedge pclk) disable iff (!presetn) // see R21
        (state_reg != ST_SHIFT) && !$past(state_reg == ST_SHIFT) |-> port_pin_clk_out)
        else $error("serial clock low outside shifting");

    msb_order_a: assert property (@(posedge pclk) disable iff (!presetn) // see R19
        fall_ev && has_tx && !order_reg && !abort |=> port_pin_out == $past(tx_sh_reg[7]))
        else $error("wrong bit sent first");

    internal_start_a: assert property (@(posedge pclk) disable iff (!presetn) // see R24
        start && internal && !abort ##1 !abort [*3] |-> ##[0:1] (state_reg == ST_SHIFT))
        else $error("internal clock transfer did not start");

    rx_full_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see R14
        pop && rx_full_reg && (rd_cnt_reg == count_reg) && !abort
        && !(byte_end && last && has_rx) |=> !rx_full_reg)
        else $error("receive flag not cleared after last read");
endmodule // bsp_sync_serial_unit

// ==== verif/bsp_tb_peer.sv ====
`timescale 1ns/1ps
module bsp_tb_peer #(
    parameter logic [15:0] PAT = 16'hB41E
)(
    // Serial lines.
    input  wire logic        sck,
    input  wire logic        sdo,
    output logic             sdi,
    // Capture control.
    input  wire logic        clr,
    output logic      [15:0] cap
);
    logic [15:0] pat;
    // Data moves on falls and is captured on rises, as a real peer would.
    always @(negedge sck or posedge clr) begin
        if (clr) begin
            pat <= PAT;
            sdi <= 1'b1;
        end else begin
            sdi <= pat[15];
            pat <= {pat[14:0], ~pat[15]};
        end
    end
    always @(posedge sck or posedge clr) begin
        if (clr) cap <= 16'h0000;
        else cap <= {cap[14:0], sdo};
    end
endmodule // bsp_tb_peer

// ==== verif/tb_bsp_sync_serial_unit.sv ====
`timescale 1ns/1ps
module tb_bsp_sync_serial_unit;
    import bsp_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, sdi, sdo, clk_out, oe_n, sck;
    logic [15:0] cap;
    logic        ext_sck = 1'b1;
    int          error_cnt = 0, check_count = 0, cyc = 0;
    always #5 pclk = ~pclk;
    // In external mode the bench drives the clock line, which idles high.
    assign sck = oe_n ? ext_sck : clk_out;
    bsp_sync_serial_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pin_in(sdi),
        .port_pin_out(sdo), .port_pin_clk_in(sck), .port_pin_clk_out(clk_out),
        .port_pin_clk_oe_n(oe_n), .low_freq_tick(1'b0), .low_speed_mode(1'b0));
    bsp_tb_peer peer_u (.sck(sck), .sdo(sdo), .sdi(sdi), .clr(clr), .cap(cap));
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, a, e);
        end
    endtask
    // Polling keeps the bench free of any assumed transfer length.
    task automatic wait_idle;
        repeat (20) @(posedge pclk);
        do apb(1'b0, IDX_STATUS, 8'h00); while (rd[6] !== 1'b0);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        @(posedge pclk);
        clr <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h20);
        apb(1'b1, IDX_STATUS, 8'hFF);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h20);
        apb(1'b0, 6'h00, 8'h00);
        chk(err, 32'h1);
        // Two bytes out, MSB first, fastest divider within one megabit.
        apb(1'b1, IDX_CTRL, 8'h01);
        apb(1'b1, IDX_COUNT, 8'h01);
        apb(1'b1, IDX_DATA, 8'hC5);
        apb(1'b1, IDX_DATA, 8'h3A);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd[5], 32'h0);
        apb(1'b1, IDX_CTRL, 8'h81);
        wait_idle();
        chk(cap, 32'hC53A);
        chk(rd, 32'hA0);
        chk(sck, 32'h1);
        apb(1'b1, IDX_CTRL, 8'h01);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd[7], 32'h0);
        // Full duplex, LSB first.
        clr <= 1'b1;
        apb(1'b1, IDX_CTRL, 8'h29);
        clr <= 1'b0;
        apb(1'b1, IDX_DATA, 8'hC5);
        apb(1'b1, IDX_DATA, 8'h3A);
        apb(1'b1, IDX_CTRL, 8'hA9);
        wait_idle();
        chk(rd, 32'hB0);
        chk(cap, 32'hA35C);
        apb(1'b0, IDX_DATA, 8'h00);
        chk(rd, 32'h2D);
        apb(1'b0, IDX_DATA, 8'h00);
        chk(rd, 32'h78);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd[4], 32'h0);
        // External clock, one byte each way, then one pulse too many.
        apb(1'b1, IDX_CTRL, 8'h29);
        apb(1'b1, IDX_COUNT, 8'h00);
        apb(1'b1, IDX_CTRL, 8'h2F);
        apb(1'b1, IDX_DATA, 8'h96);
        clr <= 1'b1;
        apb(1'b1, IDX_CTRL, 8'hAF);
        clr <= 1'b0;
        repeat (9) begin
            repeat (50) @(posedge pclk);
            ext_sck <= ~ext_sck;
            repeat (50) @(posedge pclk);
            ext_sck <= ~ext_sck;
        end
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'hBC);
        chk({sdo, cap[8:0]}, 32'h2D3);
        apb(1'b0, IDX_DATA, 8'h00);
        chk(rd, 32'h2D);
        apb(1'b1, IDX_CTRL, 8'h2F);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h2C);
        apb(1'b1, IDX_CTRL, 8'h6F);
        apb(1'b1, IDX_COUNT, 8'h01);
        // Abort in mid-byte wipes run, flags and buffer state.
        apb(1'b1, IDX_CTRL, 8'h29);
        apb(1'b1, IDX_DATA, 8'h5A);
        apb(1'b1, IDX_DATA, 8'hA5);
        apb(1'b1, IDX_CTRL, 8'hA9);
        repeat (300) @(posedge pclk);
        apb(1'b1, IDX_CTRL, 8'h69);
        apb(1'b0, IDX_STATUS, 8'h00);
        chk(rd, 32'h20);
        apb(1'b0, IDX_CTRL, 8'h00);
        chk(rd, 32'h29);
        end_sim();
    end
endmodule // tb_bsp_sync_serial_unit
